// ### src/ust_pkg.sv
// Shared constants and types for the serial transmitter with smartcard framing.
package ust_pkg;

    // Register offsets on the plain register port.
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_BAUD = 8'h08;
    localparam logic [7:0] OFF_TXDATA = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_RXDATA = 8'h14;

    // Field positions.
    localparam int C1_EN_POS = 0;
    localparam int C1_WL_LSB = 1;
    localparam int C1_PAR_POS = 3;
    localparam int C1_SC_POS = 4;
    localparam int C1_BRK_POS = 5;
    localparam int C2_STOP_LSB = 12;
    localparam int C2_DINV_POS = 18;
    localparam int C2_MSBF_POS = 19;
    localparam int ST_TXE_POS = 0;
    localparam int ST_TC_POS = 1;
    localparam int ST_PE_POS = 2;
    localparam int ST_RXNE_POS = 3;

    // Word length and stop bit codes.
    localparam logic [1:0] WL_8 = 2'h0;
    localparam logic [1:0] WL_9 = 2'h1;
    localparam logic [1:0] WL_7 = 2'h2;
    localparam logic [1:0] STOP_1 = 2'h0;
    localparam logic [1:0] STOP_HALF = 2'h1;
    localparam logic [1:0] STOP_2 = 2'h2;
    localparam logic [1:0] STOP_1P5 = 2'h3;

    // Reset values.
    localparam logic [15:0] BAUD_RESET = 16'h0010;
    localparam logic [1:0] STOP_RESET = STOP_1;
    localparam logic [1:0] WL_RESET = WL_8;

    // Frame timing, counted in half bit periods.
    localparam logic [4:0] HALVES_PER_BIT = 5'h02;
    localparam logic [4:0] BRK_STOP_HALVES = 5'h04;

    typedef enum logic [3:0] {
        TX_OFF, TX_IDLEFR, TX_READY, TX_START, TX_DATA, TX_STOP, TX_BRK, TX_BRKSTOP, TX_ERRSIG
    } ust_tx_state_type;

    typedef enum logic [1:0] {
        RX_IDLE, RX_START, RX_BITS
    } ust_rx_state_type;

endpackage

// ### src/ust_sc_rx.sv
// Smartcard character receiver that checks even parity over moments 2 to 10.
`timescale 1ns/1ns
`default_nettype none
module ust_sc_rx
    import ust_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic half_tick_in,
    input wire logic enable_in,
    input wire logic rx_in,
    input wire logic bit_order_sel_in,
    input wire logic data_polarity_invert_in,
    output logic [7:0] data_out,
    output logic valid_out,
    output logic parity_err_out
);

    typedef struct packed {
        ust_rx_state_type st;
        logic prev;
        logic hc;
        logic [3:0] idx;
        logic [8:0] sh;
        logic [7:0] data;
        logic valid;
        logic perr;
    } ust_rx_regs_type;

    ust_rx_regs_type s;
    ust_rx_regs_type next_s;
    logic [8:0] shifted;
    logic [7:0] reversed;

    // Byte reversal for the most significant bit first order.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_rev
            assign reversed[gi] = shifted[7 - gi];
        end
    endgenerate

    assign shifted = {rx_in ^ data_polarity_invert_in, s.sh[8:1]};

    always_comb
    begin
        next_s = s;
        next_s.prev = rx_in;
        next_s.valid = 1'b0;
        next_s.perr = 1'b0;
        unique case (s.st)
            RX_IDLE:
            begin
                if (enable_in && s.prev && !rx_in)
                begin
                    next_s.st = RX_START;
                end
            end
            RX_START:
            begin
                // Sampling is on the half bit grid, so phase error is up to half a bit.
                if (half_tick_in)
                begin
                    next_s.st = rx_in ? RX_IDLE : RX_BITS;
                    next_s.hc = 1'b1;
                    next_s.idx = 4'h0;
                end
            end
            RX_BITS:
            begin
                if (half_tick_in)
                begin
                    next_s.hc = ~s.hc;
                    if (!s.hc)
                    begin
                        next_s.sh = shifted;
                        next_s.idx = s.idx + 4'h1;
                        if (s.idx == 4'h8)
                        begin
                            next_s.st = RX_IDLE;
                            next_s.valid = 1'b1;
                            next_s.perr = ^shifted; // [R17] [R19]
                            next_s.data = bit_order_sel_in ? reversed : shifted[7:0];
                        end
                    end
                end
            end
        endcase
        if (!enable_in)
        begin
            next_s.st = RX_IDLE;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign data_out = s.data;
    assign valid_out = s.valid;
    assign parity_err_out = s.perr;

    AST_RX_PULSE: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // [R20]
        s.valid |=> !s.valid) else $error("Receive valid pulse lasted more than one cycle.");

    AST_RX_PERR_WITH_VALID: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // [R17]
        s.perr |-> s.valid) else $error("Parity error reported without a received character.");

endmodule
`default_nettype wire

// ### src/ust_tx_top.sv
// Serial transmitter with register port, fractional stop bits, break and smartcard conventions.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// R01 - Word length of 7, 8 or 9 bits.
// R02 - Software enables before writing a character.
// R03 - Shift register drives line and clock pin.
// R04 - Least significant bit first by default.
// R05 - Holding buffer sits before the shifter.
// R06 - Start bit low for one bit.
// R07 - Stop field picks 0.5, 1, 1.5, 2.
// R08 - Software picks stop bits per mode.
// R09 - Enabling sends an idle frame first.
// R10 - Dropping enable freezes and loses character.
// R11 - Break is 10, 11 or 9 lows.
// R12 - No breaks longer than fixed count.
// R13 - Block check codes are software's job.
// R14 - Both bits clear gives direct convention.
// R15 - Both bits set gives inverse convention.
// R16 - Parity bit inverted like data bits.
// R17 - Parity good when moments hold even ones.
// R18 - Card sends initial character first.
// R19 - Initial character pattern not recognised here.
// R20 - Parity error flags and signals card.
// R21 - Card retries after the error signal.
// R22 - Holding buffer empty once moved to shifter.
module ust_tx_top
    import ust_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic rx_pin_in,
    output logic tx_out,
    output logic sync_clk_out
);

    typedef struct packed {
        ust_tx_state_type st;
        logic tx_enable_bit;
        logic [1:0] wl;
        logic par_en;
        logic sc_mode;
        logic brk_req;
        logic [1:0] stop;
        logic data_polarity_invert;
        logic bit_order_sel;
        logic [15:0] baud;
        logic [15:0] bcnt;
        logic [4:0] hcnt;
        logic [3:0] bit_idx;
        logic [8:0] tx_holding_buffer;
        logic buf_full;
        logic [8:0] shreg;
        logic pe_flag;
        logic err_pend;
        logic [7:0] rxd;
        logic rxne;
        logic tx_line;
        logic sck;
        logic [31:0] rdata;
    } ust_regs_type;

    ust_regs_type s;
    ust_regs_type next_s;

    logic rst_meta_b;
    logic rst_sync_b;
    logic rx_meta;
    logic rx_sync;
    logic half_tick;
    logic [3:0] nbits;
    logic [4:0] stop_halves;
    logic [8:0] word;
    logic [8:0] ordered;
    logic parity;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_perr;

    // Reset is asserted at once and released through two flops.
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // The line input is asynchronous, so only the second flop is used.
    always_ff @(posedge sys_clk_in or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end
        else
        begin
            rx_meta <= rx_pin_in;
            rx_sync <= rx_meta;
        end
    end

    // Word length decode.
    always_comb
    begin
        unique case (s.wl)
            WL_9: nbits = 4'h9; // [R01]
            WL_7: nbits = 4'h7;
            default: nbits = 4'h8;
        endcase
    end

    // Stop bits counted in half bit periods allow the fractional settings.
    always_comb
    begin
        unique case (s.stop)
            STOP_HALF: stop_halves = 5'h01; // [R07]
            STOP_2: stop_halves = 5'h04;
            STOP_1P5: stop_halves = 5'h03;
            default: stop_halves = 5'h02;
        endcase
    end

    // Character preparation: parity replaces the top data bit when enabled.
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++)
        begin : g_word
            assign word[gi] = (s.par_en && gi == int'(nbits) - 1) ? parity :
                ((gi < int'(nbits)) ? s.tx_holding_buffer[gi] : 1'b0);
            assign ordered[gi] = (s.bit_order_sel && gi < int'(nbits)) ? word[int'(nbits) - 1 - gi] : word[gi]; // [R04] [R14] [R15]
        end
    endgenerate

    always_comb
    begin
        parity = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (i < int'(nbits) - 1)
            begin
                parity = parity ^ s.tx_holding_buffer[i];
            end
        end
    end

    // The baud counter runs only while the transmitter is enabled.
    assign half_tick = (s.st != TX_OFF) && (s.bcnt == 16'h0000);

    ust_sc_rx u_rx (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_sync_b),
        .half_tick_in(half_tick),
        .enable_in(s.tx_enable_bit),
        .rx_in(rx_sync),
        .bit_order_sel_in(s.bit_order_sel),
        .data_polarity_invert_in(s.data_polarity_invert),
        .data_out(rx_data),
        .valid_out(rx_valid),
        .parity_err_out(rx_perr)
    );

    always_comb
    begin
        next_s = s;
        next_s.rdata = 32'h0000_0000;
        if (rd_in)
        begin
            unique case (addr_in)
                OFF_CTRL1: next_s.rdata = {26'h0, s.brk_req, s.sc_mode, s.par_en, s.wl, s.tx_enable_bit};
                OFF_CTRL2: next_s.rdata = {12'h0, s.bit_order_sel, s.data_polarity_invert, 4'h0, s.stop, 12'h0};
                OFF_BAUD: next_s.rdata = {16'h0, s.baud};
                OFF_STATUS: next_s.rdata = {28'h0, s.rxne, s.pe_flag, (s.st == TX_READY) && !s.buf_full, !s.buf_full};
                OFF_RXDATA: next_s.rdata = {24'h0, s.rxd};
                default: next_s.rdata = 32'h0000_0000;
            endcase
            if (addr_in == OFF_RXDATA)
            begin
                next_s.rxne = 1'b0;
            end
        end
        if (wr_in)
        begin
            unique case (addr_in)
                OFF_CTRL1:
                begin
                    next_s.tx_enable_bit = wdata_in[C1_EN_POS];
                    next_s.wl = wdata_in[C1_WL_LSB +: 2];
                    next_s.par_en = wdata_in[C1_PAR_POS];
                    next_s.sc_mode = wdata_in[C1_SC_POS];
                    next_s.brk_req = s.brk_req | wdata_in[C1_BRK_POS];
                end
                OFF_CTRL2:
                begin
                    next_s.stop = wdata_in[C2_STOP_LSB +: 2]; // [R07]
                    next_s.data_polarity_invert = wdata_in[C2_DINV_POS];
                    next_s.bit_order_sel = wdata_in[C2_MSBF_POS];
                end
                OFF_BAUD: next_s.baud = wdata_in[15:0];
                OFF_STATUS:
                begin
                    if (wdata_in[ST_PE_POS])
                    begin
                        next_s.pe_flag = 1'b0;
                    end
                end
                default:
                begin
                end
            endcase
        end
        // Received characters; a new event wins over a clear in the same cycle.
        if (rx_valid)
        begin
            next_s.rxd = rx_data;
            next_s.rxne = 1'b1;
        end
        if (rx_perr)
        begin
            next_s.pe_flag = 1'b1; // [R20]
            next_s.err_pend = s.sc_mode; // [R20]
        end
        if (s.st != TX_OFF)
        begin
            next_s.bcnt = half_tick ? s.baud - 16'h0001 : s.bcnt - 16'h0001;
        end
        if (half_tick)
        begin
            next_s.hcnt = s.hcnt - 5'h01;
        end
        unique case (s.st)
            TX_OFF:
            begin
                next_s.tx_line = 1'b1;
                if (s.tx_enable_bit)
                begin
                    next_s.st = TX_IDLEFR; // [R09]
                    next_s.hcnt = (5'(nbits) + 5'h01) * HALVES_PER_BIT + stop_halves;
                    next_s.bcnt = s.baud - 16'h0001;
                end
            end
            TX_READY:
            begin
                // New frames start on the half bit grid so every bit has full length.
                if (half_tick)
                begin
                    if (s.err_pend && !rx_perr)
                    begin
                        next_s.st = TX_ERRSIG; // [R20]
                        next_s.err_pend = 1'b0;
                        next_s.tx_line = 1'b0;
                        next_s.hcnt = HALVES_PER_BIT;
                    end
                    else if (s.brk_req)
                    begin
                        next_s.st = TX_BRK; // [R11] [R12]
                        next_s.brk_req = wr_in && addr_in == OFF_CTRL1 && wdata_in[C1_BRK_POS];
                        next_s.tx_line = 1'b0;
                        next_s.hcnt = (5'(nbits) + 5'h02) * HALVES_PER_BIT;
                    end
                    else if (s.buf_full)
                    begin
                        next_s.st = TX_START; // [R06]
                        next_s.shreg = ordered; // [R05]
                        next_s.buf_full = 1'b0; // [R22]
                        next_s.tx_line = 1'b0;
                        next_s.hcnt = HALVES_PER_BIT;
                    end
                end
            end
            TX_START:
            begin
                if (half_tick && s.hcnt == 5'h01)
                begin
                    next_s.st = TX_DATA;
                    next_s.bit_idx = 4'h0;
                    next_s.tx_line = s.shreg[0] ^ s.data_polarity_invert; // [R03] [R16]
                    next_s.hcnt = HALVES_PER_BIT;
                end
            end
            TX_DATA:
            begin
                if (half_tick && s.hcnt == 5'h01)
                begin
                    next_s.shreg = {1'b0, s.shreg[8:1]};
                    if (s.bit_idx == nbits - 4'h1)
                    begin
                        next_s.st = TX_STOP;
                        next_s.tx_line = 1'b1;
                        next_s.hcnt = stop_halves; // [R07]
                    end
                    else
                    begin
                        next_s.bit_idx = s.bit_idx + 4'h1;
                        next_s.tx_line = s.shreg[1] ^ s.data_polarity_invert; // [R16]
                        next_s.hcnt = HALVES_PER_BIT;
                    end
                end
            end
            TX_BRK:
            begin
                if (half_tick && s.hcnt == 5'h01)
                begin
                    next_s.st = TX_BRKSTOP; // [R11]
                    next_s.tx_line = 1'b1;
                    next_s.hcnt = BRK_STOP_HALVES;
                end
            end
            TX_IDLEFR, TX_STOP, TX_BRKSTOP, TX_ERRSIG:
            begin
                if (half_tick && s.hcnt == 5'h01)
                begin
                    next_s.st = TX_READY;
                    next_s.tx_line = 1'b1;
                end
            end
        endcase
        // A write lands after any load above, so a write in the load cycle is kept.
        if (wr_in && addr_in == OFF_TXDATA)
        begin
            next_s.tx_holding_buffer = wdata_in[8:0]; // [R05]
            next_s.buf_full = 1'b1;
        end
        // Dropping the enable stops the counters and abandons the character.
        if (!s.tx_enable_bit)
        begin
            next_s.st = TX_OFF; // [R10]
            next_s.tx_line = 1'b1;
            next_s.bcnt = s.bcnt;
        end
        next_s.sck = (next_s.st == TX_DATA) && (next_s.hcnt == 5'h01); // [R03]
    end

    always_ff @(posedge sys_clk_in or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            s <= '0;
            s.st <= TX_OFF;
            s.wl <= WL_RESET;
            s.stop <= STOP_RESET;
            s.baud <= BAUD_RESET;
            s.tx_line <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign rdata_out = s.rdata;
    assign tx_out = s.tx_line;
    assign sync_clk_out = s.sck;

    AST_START_LOW: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b) // [R06]
        (s.st == TX_START) |-> !tx_out) else $error("Start bit is not low.");

    AST_START_END: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b) // [R06]
        (s.st == TX_START && half_tick && s.hcnt == 5'h01 && s.tx_enable_bit) |=> (s.st == TX_DATA && s.bit_idx == 4'h0))
        else $error("Start bit did not end after one bit period.");

    AST_EN_FREEZE: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b) // [R10]
        (!s.tx_enable_bit && s.st != TX_OFF) |=> (s.st == TX_OFF && tx_out && s.bcnt == $past(s.bcnt)))
        else $error("Clearing enable did not stop the transmitter.");

    AST_IDLE_FIRST: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b) // [R09]
        (s.st == TX_OFF && s.tx_enable_bit) |=> (s.st == TX_IDLEFR && tx_out && s.hcnt == (5'($past(nbits)) + 5'h01) * 5'h02 + $past(stop_halves)))
        else $error("Idle frame missing or wrong length after enable.");

    AST_STOP_LEN: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b) // [R07]
        $rose(s.st == TX_STOP) |-> (tx_out && s.hcnt == stop_halves)) else $error("Stop bits wrong.");

    AST_BRK_LEN: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b) // [R11]
        $rose(s.st == TX_BRK) |-> (!tx_out && s.hcnt == (5'(nbits) + 5'h02) * 5'h02)) else $error("Break length wrong.");

    AST_LOAD_EMPTIES: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b) // [R22]
        (s.st == TX_READY && half_tick && s.buf_full && !s.err_pend && !s.brk_req && s.tx_enable_bit
        && !(wr_in && addr_in == OFF_TXDATA)) |=> (s.st == TX_START && !s.buf_full))
        else $error("Holding buffer not emptied on load.");

    AST_DATA_LINE: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b) // [R16]
        (s.st == TX_DATA && $stable(s.data_polarity_invert)) |-> (tx_out == (s.shreg[0] ^ s.data_polarity_invert)))
        else $error("Data bit on the line does not match shifter and polarity.");

    AST_SCK_IN_DATA: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b) // [R03]
        sync_clk_out |-> (s.st == TX_DATA)) else $error("Clock pulse outside data bits.");

endmodule
`default_nettype wire

// ### test/ust_card_model.sv
// Smartcard that sends the initial character and retries on an error signal.
`timescale 1ns/1ns
`default_nettype none
module ust_card_model
#(
    parameter int BIT_CYCLES = 4
)
(
    input wire logic clk_in,
    input wire logic err_line_in,
    output logic data_line_out
);
    // Inverse-convention initial character, moment 1 in the top bit; the model drives the line high when idle.
    localparam logic [9:0] FIRST_CHAR = 10'h181;
    initial data_line_out = 1'h1;
    task automatic send_char;
        for (int i = 9; i >= 0; i--)
        begin
            @(posedge clk_in);
            data_line_out <= FIRST_CHAR[i];
            repeat (BIT_CYCLES - 1) @(posedge clk_in);
        end
        @(posedge clk_in);
        data_line_out <= 1'h1;
    endtask
    // The retry waits long enough for the host to reprogram its convention.
    task automatic answer_reset;
        int seen;
        seen = 0;
        send_char();
        repeat (15 * BIT_CYCLES)
        begin
            @(posedge clk_in);
            if (err_line_in === 1'h0)
                seen = 1;
        end
        if (seen == 1)
            send_char();
    endtask
endmodule
`default_nettype wire

// ### test/ust_tx_top_test.sv
// Self-checking bench for the serial transmitter with smartcard framing.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module ust_tx_top_test
    import ust_pkg::*;
;
    // A half bit of four cycles keeps the receiver's sampling well inside each moment.
    localparam int B = 4;
    localparam int BT = 2 * B;
    logic sys_clk;
    logic rst_b;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic tx;
    logic sck;
    logic rx_line;
    int miscompares = 0;
    int check_count = 0;
    logic [31:0] d;
    logic [8:0] bits;
    int n;
    ust_tx_top u_dut (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .rx_pin_in(rx_line), .tx_out(tx), .sync_clk_out(sck));
    ust_card_model #(.BIT_CYCLES(BT)) u_card (.clk_in(sys_clk), .err_line_in(tx), .data_line_out(rx_line));
    initial
    begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'h1;
        @(posedge sys_clk);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge sys_clk);
        rd <= 1'h0;
        #1 v = rdata;
    endtask
    function automatic logic [31:0] c1(logic en, logic [1:0] wl, logic par, logic sc, logic brk);
        return (32'(en) << C1_EN_POS) | (32'(wl) << C1_WL_LSB) | (32'(par) << C1_PAR_POS)
            | (32'(sc) << C1_SC_POS) | (32'(brk) << C1_BRK_POS);
    endfunction
    // Falling edges see a settled line.
    task automatic wait_low(output int k);
        k = 0;
        while (tx !== 1'h0 && k < 3000)
        begin
            @(negedge sys_clk);
            k++;
        end
        `CHK("line start", 1'h1, k < 3000)
    endtask
    task automatic run(input logic lv, output int k);
        k = 0;
        while (tx === lv && k < 200)
        begin
            k++;
            @(negedge sys_clk);
        end
    endtask
    task automatic cap(input int nb, output logic [8:0] bv, output int k);
        bv = 9'h000;
        wait_low(k);
        repeat (B) @(negedge sys_clk);
        `CHK("start bit", 2'h0, {tx, sck})
        for (int i = 0; i < nb; i++)
        begin
            repeat (BT) @(negedge sys_clk);
            bv[i] = tx;
            `CHK("clock", 1'h1, sck)
        end
    endtask
    task automatic test_reset;
        rd_reg(OFF_STATUS, d);
        `CHK("empty after reset", 1'h1, d[ST_TXE_POS])
        rd_reg(OFF_CTRL2, d);
        `CHK("ctrl2 reset", 32'h0000_0000, d)
        rd_reg(8'h20, d);
        `CHK("unmapped read", 32'h0000_0000, d)
    endtask
    task automatic test_frames;
        wr_reg(OFF_BAUD, 32'(B));
        wr_reg(OFF_CTRL1, c1(1'h1, WL_8, 1'h0, 1'h0, 1'h0));
        wr_reg(OFF_TXDATA, 32'h0000_00A3);
        cap(8, bits, n);
        `CHK("idle frame length", 1'h1, n >= 9 * BT)
        `CHK("lsb first byte", 9'h0A3, bits)
        repeat (3 * BT) @(negedge sys_clk);
        rd_reg(OFF_STATUS, d);
        `CHK("empty and complete", 2'h3, {d[ST_TC_POS], d[ST_TXE_POS]})
        wr_reg(OFF_CTRL1, c1(1'h1, WL_7, 1'h0, 1'h0, 1'h0));
        wr_reg(OFF_TXDATA, 32'h0000_01A5);
        cap(7, bits, n);
        `CHK("seven bit word", 9'h025, bits)
        repeat (3 * BT) @(negedge sys_clk);
        wr_reg(OFF_CTRL1, c1(1'h1, WL_9, 1'h0, 1'h0, 1'h0));
        wr_reg(OFF_TXDATA, 32'h0000_01A5);
        cap(9, bits, n);
        `CHK("nine bit word", 9'h1A5, bits)
        repeat (3 * BT) @(negedge sys_clk);
        wr_reg(OFF_CTRL2, 32'h000C_0000);
        wr_reg(OFF_CTRL1, c1(1'h1, WL_8, 1'h0, 1'h0, 1'h0));
        wr_reg(OFF_TXDATA, 32'h0000_003B);
        cap(8, bits, n);
        `CHK("inverse convention", 9'h023, bits)
        repeat (3 * BT) @(negedge sys_clk);
        wr_reg(OFF_CTRL2, 32'h0004_0000);
        wr_reg(OFF_CTRL1, c1(1'h1, WL_9, 1'h1, 1'h0, 1'h0));
        wr_reg(OFF_TXDATA, 32'h0000_00B5);
        cap(9, bits, n);
        `CHK("inverted parity", 9'h04A, bits)
        repeat (3 * BT) @(negedge sys_clk);
    endtask
    task automatic test_stop;
        logic [1:0] codes [4];
        codes = '{STOP_HALF, STOP_1, STOP_1P5, STOP_2};
        wr_reg(OFF_CTRL1, c1(1'h1, WL_8, 1'h0, 1'h0, 1'h0));
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(OFF_CTRL2, 32'(codes[i]) << C2_STOP_LSB);
            wr_reg(OFF_TXDATA, 32'h0000_0000);
            wait_low(n);
            wr_reg(OFF_TXDATA, 32'h0000_0000);
            repeat (9 * BT - 1) @(negedge sys_clk);
            run(1'h1, n);
            `CHK("stop length", 1'h1, n >= (i + 1) * B && n <= (i + 2) * B)
            repeat (12 * BT) @(negedge sys_clk);
        end
        wr_reg(OFF_CTRL2, 32'h0000_0000);
    endtask
    task automatic test_break;
        logic [1:0] wls [3];
        wls = '{WL_8, WL_9, WL_7};
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(OFF_CTRL1, c1(1'h1, wls[i], 1'h0, 1'h0, 1'h1));
            wait_low(n);
            run(1'h0, n);
            `CHK("break lows", (10 + (i == 1) - (i == 2)) * BT, n)
            run(1'h1, n);
            `CHK("break stop", 1'h1, n >= 2 * BT)
        end
    endtask
    task automatic test_disable;
        wr_reg(OFF_CTRL1, c1(1'h1, WL_8, 1'h0, 1'h0, 1'h0));
        wr_reg(OFF_TXDATA, 32'h0000_0000);
        wait_low(n);
        repeat (3 * BT) @(negedge sys_clk);
        wr_reg(OFF_CTRL1, c1(1'h0, WL_8, 1'h0, 1'h0, 1'h0));
        repeat (2) @(negedge sys_clk);
        run(1'h1, n);
        `CHK("line held high", 200, n)
        wr_reg(OFF_CTRL1, c1(1'h1, WL_8, 1'h0, 1'h0, 1'h0));
        run(1'h1, n);
        `CHK("character lost", 200, n)
    endtask
    task automatic test_card;
        wr_reg(OFF_CTRL1, c1(1'h1, WL_8, 1'h0, 1'h1, 1'h0));
        wr_reg(OFF_STATUS, 32'h0000_0004);
        fork
            u_card.answer_reset();
            begin
                wait_low(n);
                run(1'h0, n);
                `CHK("error signal", BT, n)
            end
            begin
                d = 32'h0000_0000;
                for (int k = 0; k < 200 && d[ST_PE_POS] !== 1'h1; k++)
                    rd_reg(OFF_STATUS, d);
                `CHK("parity error", 1'h1, d[ST_PE_POS])
                rd_reg(OFF_RXDATA, d);
                `CHK("direct reading", 8'h03, d[7:0])
                wr_reg(OFF_CTRL2, 32'h000C_3000);
                wr_reg(OFF_STATUS, 32'h0000_0004);
                d = 32'h0000_0000;
                for (int k = 0; k < 200 && d[ST_RXNE_POS] !== 1'h1; k++)
                    rd_reg(OFF_STATUS, d);
                rd_reg(OFF_RXDATA, d);
                `CHK("inverse reading", 8'h3F, d[7:0])
                rd_reg(OFF_STATUS, d);
                `CHK("parity good", 1'h0, d[ST_PE_POS])
            end
        join
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        miscompares++;
        wrap_up();
    end
    initial
    begin
        rst_b = 1'h0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'h0;
        rd = 1'h0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge sys_clk);
        test_reset();
        test_frames();
        test_stop();
        test_break();
        test_disable();
        test_card();
        wrap_up();
    end
endmodule
`default_nettype wire
